// ==== logic/pulse_counter_pkg.sv ====
// constants and types shared by the dual pulse counter
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package pulse_counter_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_RAW1 = 8'h00;
  localparam logic [7:0] OFF_SCALED1 = 8'h04;
  localparam logic [7:0] OFF_TARGET1 = 8'h08;
  localparam logic [7:0] OFF_LIMIT1 = 8'h0c;
  localparam logic [7:0] OFF_NUM1 = 8'h10;
  localparam logic [7:0] OFF_DEN1 = 8'h14;
  localparam logic [7:0] OFF_COUNT2 = 8'h18;
  localparam logic [7:0] OFF_TARGET2 = 8'h1c;
  localparam logic [7:0] OFF_LIMIT2 = 8'h20;
  localparam logic [7:0] OFF_CTRL1 = 8'h24;
  localparam logic [7:0] OFF_CTRL2 = 8'h28;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h2c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h30;
  localparam logic [7:0] OFF_LIVE = 8'h34;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [31:0] TARGET1_RST = 32'h0000_03e8;
  localparam logic [31:0] LIMIT1_RST = 32'hffff_ffff;
  localparam logic [15:0] GEAR_RST = 16'h0001;
  localparam logic [15:0] TARGET2_RST = 16'h03e8;
  localparam logic [15:0] LIMIT2_RST = 16'hffff;
  localparam logic [15:0] CTRL1_RST = 16'h000b;
  localparam logic [15:0] CTRL2_RST = 16'h006f;

  // ----------------------------------------------------------------
  // control word digits and interrupt bits
  // ----------------------------------------------------------------
  localparam logic [15:0] DIGIT_ONES = 16'h0001;
  localparam logic [15:0] DIGIT_TENS = 16'h000a;
  localparam logic [15:0] DIGIT_HUNDREDS = 16'h0064;
  localparam int IRQ_W = 4;
  localparam int IRQ_REACH1 = 0;
  localparam int IRQ_REACH2 = 1;
  localparam int IRQ_OVF1 = 2;
  localparam int IRQ_OVF2 = 3;

  typedef enum logic [1:0] {ACT_RUN, ACT_COAST, ACT_DECEL, ACT_ESTOP} drive_act_t;

endpackage

// ==== logic/gear_div_if.sv ====
// divider request and answer between counter core and gear divider
`timescale 1ns/1ps
interface gear_div_if #(parameter int W = 48, parameter int DW = 16);
  logic start;
  logic [W-1:0] dividend;
  logic [DW-1:0] divisor;
  logic busy;
  logic done;
  logic [W-1:0] quotient;
  modport master (output start, output dividend, output divisor,
                  input busy, input done, input quotient);
  modport slave (input start, input dividend, input divisor,
                 output busy, output done, output quotient);
endinterface

// ==== logic/gear_divider.sv ====
// restoring divider, one quotient bit per enabled cycle
`timescale 1ns/1ps
module gear_divider #(
  parameter int W = 48,
  parameter int DW = 16
) (
  // clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // request and answer
  gear_div_if.slave d
);
  import pulse_counter_pkg::*;

  localparam int CW = $clog2(W + 1);

  typedef enum logic {DV_IDLE, DV_RUN} dv_state_t;
  typedef struct packed {
    dv_state_t st;
    logic [CW-1:0] cnt;
    logic [DW-1:0] rem;
    logic [W-1:0] quo;
    logic [W-1:0] dvd;
    logic [DW-1:0] dvs;
    logic done;
  } dv_t;

  dv_t s;
  dv_t n;
  logic [DW:0] trial;

  always_comb begin
    n = s;
    n.done = 1'b0;
    trial = {s.rem, s.quo[W-1]};
    case (s.st)
      DV_IDLE: begin
        if (d.start) begin
          n.quo = d.dividend;
          n.dvd = d.dividend;
          n.dvs = d.divisor;
          n.rem = '0;
          n.cnt = CW'(W);
          n.st = DV_RUN;
        end
      end
      DV_RUN: begin
        // remainder dropped at the end: truncation toward zero
        n.quo = {s.quo[W-2:0], 1'b0};
        if (trial >= {1'b0, s.dvs}) begin
          n.rem = DW'(trial - {1'b0, s.dvs});
          n.quo[0] = 1'b1;
        end else begin
          n.rem = trial[DW-1:0];
        end
        n.cnt = s.cnt - CW'(1);
        if (s.cnt == CW'(1)) begin
          n.done = 1'b1;
          n.st = DV_IDLE;
        end
      end
      default: n.st = DV_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  assign d.busy = (s.st == DV_RUN);
  assign d.done = s.done;
  assign d.quotient = s.quo;

  a_div_trunc: assert property (@(posedge pclk) disable iff (!presetn)
    s.done |-> ((2*W)'(s.quo) * (2*W)'(s.dvs) <= (2*W)'(s.dvd)) &&
      ((2*W)'(s.dvd) - (2*W)'(s.quo) * (2*W)'(s.dvs) < (2*W)'(s.dvs)))
    else $error("divider quotient not truncated");

endmodule

// ==== logic/dual_pulse_counter.sv ====
// dual pulse counter with gear scaling, apb registers and interrupt
`timescale 1ns/1ps
module dual_pulse_counter (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // input terminal functions
  input wire logic count1_pulse,
  input wire logic first_counter_clear,
  input wire logic count2_pulse,
  input wire logic power_down,
  // output terminal functions
  output logic count1_reached,
  output logic count2_reached,
  output pulse_counter_pkg::drive_act_t count1_action,
  output pulse_counter_pkg::drive_act_t count2_action,
  output logic irq
);
  import pulse_counter_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] raw1;
    logic [31:0] scaled1;
    logic [31:0] cand1;
    logic wait1;
    logic [31:0] target1;
    logic [31:0] limit1;
    logic [15:0] num1;
    logic [15:0] den1;
    logic [15:0] count2;
    logic [15:0] target2;
    logic [15:0] limit2;
    logic [15:0] ctrl1;
    logic [15:0] ctrl2;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imask;
    logic p1_d;
    logic p2_d;
    logic reach1;
    logic reach2;
    drive_act_t act1;
    drive_act_t act2;
    logic irq;
  } st_t;

  localparam st_t S_RST = '{
    target1: TARGET1_RST,
    limit1: LIMIT1_RST,
    num1: GEAR_RST,
    den1: GEAR_RST,
    target2: TARGET2_RST,
    limit2: LIMIT2_RST,
    ctrl1: CTRL1_RST,
    ctrl2: CTRL2_RST,
    act1: ACT_RUN,
    act2: ACT_RUN,
    default: '0
  };

  st_t s;
  st_t n;

  gear_div_if #(.W(48), .DW(16)) dv ();

  gear_divider #(.W(48), .DW(16)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(dv.slave)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] digit(input logic [15:0] w, input logic [15:0] pos);
    logic [15:0] t;
    t = (w / pos) % DIGIT_TENS;
    return t[3:0];
  endfunction

  // tens codes above three have no meaning; treated as keep running
  function automatic drive_act_t act_of(input logic [3:0] tens);
    drive_act_t a;
    a = ACT_RUN;
    if (tens <= 4'h3) begin
      a = drive_act_t'(tens[1:0]);
    end
    return a;
  endfunction

  logic wr;
  logic edge1;
  logic edge2;
  logic [3:0] ones1;
  logic [3:0] tens1;
  logic [3:0] hund1;
  logic [3:0] ones2;
  logic [3:0] tens2;
  logic [3:0] hund2;
  logic [31:0] q32;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] w1c;
  logic [31:0] next_raw;

  always_comb begin
    ones1 = digit(s.ctrl1, DIGIT_ONES);
    tens1 = digit(s.ctrl1, DIGIT_TENS);
    hund1 = digit(s.ctrl1, DIGIT_HUNDREDS);
    ones2 = digit(s.ctrl2, DIGIT_ONES);
    tens2 = digit(s.ctrl2, DIGIT_TENS);
    hund2 = digit(s.ctrl2, DIGIT_HUNDREDS);
    // quotients past 32 bits saturate so they still exceed any limit below 32'hffff_ffff
    q32 = (|dv.quotient[47:32]) ? 32'hffff_ffff : dv.quotient[31:0];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    ev = '0;
    w1c = '0;
    wr = psel & penable & pwrite;
    edge1 = count1_pulse & ~s.p1_d;
    edge2 = count2_pulse & ~s.p2_d;
    n.p1_d = count1_pulse;
    n.p2_d = count2_pulse;
    dv.start = 1'b0;
    dv.dividend = '0;
    dv.divisor = s.den1;
    next_raw = '0;

    // counter 1
    if (first_counter_clear) begin
      n.raw1 = '0;
      n.scaled1 = '0;
      n.wait1 = 1'b0;
    end else begin
      if (dv.done && s.wait1) begin
        n.wait1 = 1'b0;
        if (q32 > s.limit1) begin
          ev[IRQ_OVF1] = 1'b1;
          if (ones1 != 4'h0) begin
            n.raw1 = '0;
            n.scaled1 = '0;
          end
        end else begin
          n.raw1 = s.cand1;
          n.scaled1 = q32;
        end
      end
      // pulses that land while a division runs are not counted
      if (edge1 && !dv.busy && (!s.wait1 || dv.done)) begin
        next_raw = n.raw1 + 32'h0000_0001;
        n.cand1 = next_raw;
        n.wait1 = 1'b1;
        dv.start = 1'b1;
        dv.dividend = 48'(next_raw) * 48'(s.num1);
      end
    end

    // counter 2
    if (edge2) begin
      if ({1'b0, s.count2} + 17'h0_0001 > {1'b0, s.limit2}) begin
        ev[IRQ_OVF2] = 1'b1;
        if (ones2 != 4'h0) begin
          n.count2 = '0;
        end
      end else begin
        n.count2 = s.count2 + 16'h0001;
      end
    end

    // power-down keeps only counts marked for retention
    if (power_down) begin
      if (hund1 == 4'h0) begin
        n.raw1 = '0;
        n.scaled1 = '0;
        n.wait1 = 1'b0;
      end
      if (hund2 == 4'h0) begin
        n.count2 = '0;
      end
    end

    // set-value outputs and drive action requests
    n.reach1 = (s.scaled1 >= s.target1);
    n.reach2 = (s.count2 >= s.target2);
    n.act1 = n.reach1 ? act_of(tens1) : ACT_RUN;
    n.act2 = n.reach2 ? act_of(tens2) : ACT_RUN;
    ev[IRQ_REACH1] = n.reach1 & ~s.reach1;
    ev[IRQ_REACH2] = n.reach2 & ~s.reach2;

    // register writes; zero is outside the target, limit and gear ranges and is ignored for those
    if (wr) begin
      if (paddr == OFF_TARGET1) begin
        if (pwdata != '0) begin
          n.target1 = pwdata;
        end
      end else if (paddr == OFF_LIMIT1) begin
        if (pwdata != '0) begin
          n.limit1 = pwdata;
        end
      end else if (paddr == OFF_NUM1) begin
        if (pwdata[15:0] != '0) begin
          n.num1 = pwdata[15:0];
        end
      end else if (paddr == OFF_DEN1) begin
        if (pwdata[15:0] != '0) begin
          n.den1 = pwdata[15:0];
        end
      end else if (paddr == OFF_TARGET2) begin
        if (pwdata[15:0] != '0) begin
          n.target2 = pwdata[15:0];
        end
      end else if (paddr == OFF_LIMIT2) begin
        if (pwdata[15:0] != '0) begin
          n.limit2 = pwdata[15:0];
        end
      end else if (paddr == OFF_CTRL1) begin
        n.ctrl1 = pwdata[15:0];
      end else if (paddr == OFF_CTRL2) begin
        n.ctrl2 = pwdata[15:0];
      end else if (paddr == OFF_IRQ_STAT) begin
        w1c = pwdata[IRQ_W-1:0];
      end else if (paddr == OFF_IRQ_MASK) begin
        n.imask = pwdata[IRQ_W-1:0];
      end
    end

    // a new event wins over a clear in the same cycle
    n.ist = (s.ist & ~w1c) | ev;
    n.irq = |(n.ist & n.imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= S_RST;
    end else if (ce) begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // apb read side
  // ----------------------------------------------------------------
  always_comb begin
    prdata = '0;
    pslverr = 1'b0;
    if (paddr == OFF_RAW1) begin
      prdata = s.raw1;
    end else if (paddr == OFF_SCALED1) begin
      prdata = s.scaled1;
    end else if (paddr == OFF_TARGET1) begin
      prdata = s.target1;
    end else if (paddr == OFF_LIMIT1) begin
      prdata = s.limit1;
    end else if (paddr == OFF_NUM1) begin
      prdata = {16'h0000, s.num1};
    end else if (paddr == OFF_DEN1) begin
      prdata = {16'h0000, s.den1};
    end else if (paddr == OFF_COUNT2) begin
      prdata = {16'h0000, s.count2};
    end else if (paddr == OFF_TARGET2) begin
      prdata = {16'h0000, s.target2};
    end else if (paddr == OFF_LIMIT2) begin
      prdata = {16'h0000, s.limit2};
    end else if (paddr == OFF_CTRL1) begin
      prdata = {16'h0000, s.ctrl1};
    end else if (paddr == OFF_CTRL2) begin
      prdata = {16'h0000, s.ctrl2};
    end else if (paddr == OFF_IRQ_STAT) begin
      prdata = {28'h000_0000, s.ist};
    end else if (paddr == OFF_IRQ_MASK) begin
      prdata = {28'h000_0000, s.imask};
    end else if (paddr == OFF_LIVE) begin
      prdata = {26'h000_0000, s.act2, s.act1, s.reach2, s.reach1};
    end else begin
      pslverr = psel & penable;
    end
  end

  // frozen clock enable stalls the bus rather than losing writes
  assign pready = ce;

  assign count1_reached = s.reach1;
  assign count2_reached = s.reach2;
  assign count1_action = s.act1;
  assign count2_action = s.act2;
  assign irq = s.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_clear_zero: assert property (
    ce && first_counter_clear |=> s.raw1 == '0 && s.scaled1 == '0)
    else $error("clear did not zero counter 1");

  a_raw_step: assert property (
    ce && !first_counter_clear && !power_down && $changed(s.raw1) |->
      $past(dv.done) && s.raw1 == $past(s.cand1) || s.raw1 == '0)
    else $error("raw count moved without a finished division");

  a_scaled_gear: assert property (
    ce && dv.done && s.wait1 && !first_counter_clear && !power_down &&
      q32 <= s.limit1 |=> s.scaled1 == $past(q32) && s.raw1 == $past(s.cand1))
    else $error("scaled count not the gear quotient");

  a_hold_max: assert property (
    ce && dv.done && s.wait1 && !first_counter_clear && !power_down &&
      q32 > s.limit1 && ones1 == 4'h0 |=> $stable(s.raw1) && $stable(s.scaled1))
    else $error("hold mode changed the count");

  a_wrap_max: assert property (
    ce && dv.done && s.wait1 && !first_counter_clear && q32 > s.limit1 &&
      ones1 != 4'h0 |=> s.raw1 == '0 && s.scaled1 == '0 && s.ist[IRQ_OVF1])
    else $error("wrap mode did not restart from zero");

  a_reach_one: assert property (
    ce && s.scaled1 >= s.target1 |=> count1_reached ##0 ce |=> count1_reached ||
      $past(s.scaled1) < $past(s.target1))
    else $error("counter 1 reached output wrong");

  a_drive_act: assert property (
    ce && s.scaled1 >= s.target1 && tens1 == 4'h2 |=> count1_action == ACT_DECEL)
    else $error("drive action not taken from tens digit");

  a_count2_step: assert property (
    ce && edge2 && !power_down && s.count2 < s.limit2 |=>
      s.count2 == $past(s.count2) + 16'h0001)
    else $error("counter 2 did not step by one");

  a_reach_two: assert property (
    ce && s.count2 >= s.target2 |=> count2_reached)
    else $error("counter 2 reached output missing");

  a_power_drop: assert property (
    ce && power_down && hund1 == 4'h0 |=> s.raw1 == '0 && s.scaled1 == '0)
    else $error("power-down kept an unretained count");

endmodule

// ==== test/terminal_model.sv ====
// digital input terminal model: count pulses, clear and power loss
`timescale 1ns/1ps
module terminal_model (
  // clock
  input wire logic pclk,
  // terminal levels
  output logic count1_pulse,
  output logic first_counter_clear,
  output logic count2_pulse,
  output logic power_down
);
  initial begin
    count1_pulse = 1'b0;
    first_counter_clear = 1'b0;
    count2_pulse = 1'b0;
    power_down = 1'b0;
  end
  // ----------------------------------------------------------------
  // pulse trains
  // ----------------------------------------------------------------
  // spaced past the divider run, else pulses would be dropped
  task automatic pulse1(input int n);
    repeat (n) begin
      @(posedge pclk);
      count1_pulse <= 1'b1;
      @(posedge pclk);
      count1_pulse <= 1'b0;
      repeat (58) @(posedge pclk);
    end
  endtask
  task automatic pulse2(input int n);
    repeat (n) begin
      @(posedge pclk);
      count2_pulse <= 1'b1;
      @(posedge pclk);
      count2_pulse <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
  // ----------------------------------------------------------------
  // level inputs
  // ----------------------------------------------------------------
  task automatic hold_level(input bit pwr, input int cyc);
    @(posedge pclk);
    if (pwr) power_down <= 1'b1;
    else first_counter_clear <= 1'b1;
    repeat (cyc) @(posedge pclk);
    power_down <= 1'b0;
    first_counter_clear <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
endmodule

// ==== test/dual_pulse_counter_tb.sv ====
// self-checking bench for the dual pulse counter
`timescale 1ns/1ps
module dual_pulse_counter_tb;
  import pulse_counter_pkg::*;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic c1p, clr1, c2p, pdn, reach1, reach2, irq;
  drive_act_t act1, act2;
  int fail_count, n_checks;
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  dual_pulse_counter dual_pulse_counter_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .count1_pulse(c1p),
    .first_counter_clear(clr1), .count2_pulse(c2p), .power_down(pdn),
    .count1_reached(reach1), .count2_reached(reach2), .count1_action(act1),
    .count2_action(act2), .irq(irq));
  terminal_model terminal_model_i (.pclk(pclk), .count1_pulse(c1p),
    .first_counter_clear(clr1), .count2_pulse(c2p), .power_down(pdn));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      fail_count++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    logic [7:0] ad[13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
      8'h20, 8'h24, 8'h28, 8'h2c, 8'h30};
    logic [31:0] ex[13] = '{32'h0, 32'h0, 32'h3e8, 32'hffffffff, 32'h1, 32'h1, 32'h0,
      32'h3e8, 32'hffff, 32'hb, 32'h6f, 32'h0, 32'h0};
    for (int k = 0; k < 13; k++) begin
      rchk("reset value", ad[k], ex[k]);
    end
    check("reach1 idle", {31'h0, reach1}, 32'h0);
  endtask
  task automatic t_gear();
    wr(8'h10, 32'h3);
    wr(8'h14, 32'h2);
    wr(8'h08, 32'h4);
    wr(8'h30, 32'h1);
    terminal_model_i.pulse1(3);
    rchk("raw1", 8'h00, 32'h3);
    rchk("scaled1", 8'h04, 32'h4);
    check("reach1", {31'h0, reach1}, 32'h1);
    check("act1", {30'h0, act1}, 32'h1);
    check("irq set", {31'h0, irq}, 32'h1);
    rchk("status", 8'h2c, 32'h1);
    wr(8'h2c, 32'h1);
    repeat (2) @(posedge pclk);
    check("irq clear", {31'h0, irq}, 32'h0);
    terminal_model_i.pulse1(1);
    rchk("scaled1 on", 8'h04, 32'h6);
    check("reach1 on", {31'h0, reach1}, 32'h1);
    // ones digit stays 1 so the wrap scenario still applies
    wr(8'h24, 32'h15);
    rchk("live decel", 8'h34, 32'h9);
    check("act1 decel", {30'h0, act1}, 32'h2);
  endtask
  task automatic t_refusals();
    wr(8'h08, 32'h0);
    rchk("target1 kept", 8'h08, 32'h4);
    wr(8'h00, 32'h5);
    rchk("raw1 ro", 8'h00, 32'h4);
    rchk("unmapped", 8'h3c, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
  endtask
  task automatic t_overflow1();
    // raw 5 gives 7, equal to limit; raw 6 gives 9, past it
    wr(8'h0c, 32'h7);
    terminal_model_i.pulse1(2);
    rchk("wrap raw1", 8'h00, 32'h0);
    rchk("wrap scaled1", 8'h04, 32'h0);
    rchk("ovf1 status", 8'h2c, 32'h4);
    wr(8'h24, 32'ha);
    terminal_model_i.pulse1(6);
    rchk("hold raw1", 8'h00, 32'h5);
    rchk("hold scaled1", 8'h04, 32'h7);
    terminal_model_i.hold_level(1'b0, 4);
    rchk("clear raw1", 8'h00, 32'h0);
    rchk("clear scaled1", 8'h04, 32'h0);
  endtask
  task automatic t_counter2();
    wr(8'h28, 32'h1e);
    wr(8'h1c, 32'h2);
    wr(8'h20, 32'h3);
    terminal_model_i.pulse2(2);
    rchk("count2", 8'h18, 32'h2);
    check("reach2", {31'h0, reach2}, 32'h1);
    check("act2", {30'h0, act2}, 32'h3);
    terminal_model_i.pulse2(2);
    rchk("hold count2", 8'h18, 32'h3);
    rchk("ovf2 status", 8'h2c, 32'hf);
    for (int t = 0; t < 4; t++) begin
      wr(8'h28, t * 10);
      rchk("live", 8'h34, {26'h0, t[1:0], 4'h2});
    end
  endtask
  task automatic t_retention();
    wr(8'h28, 32'h1e);
    terminal_model_i.hold_level(1'b1, 4);
    rchk("dropped count2", 8'h18, 32'h0);
    wr(8'h28, 32'h64);
    terminal_model_i.pulse2(1);
    terminal_model_i.hold_level(1'b1, 4);
    rchk("kept count2", 8'h18, 32'h1);
  endtask
  task automatic t_freeze_reset();
    @(posedge pclk);
    ce <= 1'b0;
    terminal_model_i.pulse2(2);
    check("pready frozen", {31'h0, pready}, 32'h0);
    ce <= 1'b1;
    rchk("frozen count2", 8'h18, 32'h1);
    check("irq before reset", {31'h0, irq}, 32'h1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check("irq in reset", {31'h0, irq}, 32'h0);
    presetn <= 1'b1;
    rchk("ctrl1 after reset", 8'h24, 32'hb);
    wr(8'h20, 32'h1);
    terminal_model_i.pulse2(2);
    rchk("wrap count2", 8'h18, 32'h0);
    rchk("ovf2 after reset", 8'h2c, 32'h8);
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    fail_count = 0;
    n_checks = 0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_gear();
    t_refusals();
    t_overflow1();
    t_counter2();
    t_retention();
    t_freeze_reset();
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    complete_run();
  end
endmodule
